// ### rtl/psb_pkg.sv
// Shared constants, types and helpers for the multiplexed pseudo-static RAM link
package psb_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS        = 20;
	localparam int MAX_SELECT_PULSE_NS  = 4000;
	localparam int MAX_SELECT_PULSE_CYC = MAX_SELECT_PULSE_NS / CLK_PERIOD_NS;
	localparam int MIN_DESELECT_NS      = 100;
	localparam int MIN_DESELECT_CYC     = (MIN_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ASYNC_STEP_NS        = 120;
	localparam int ASYNC_STEP_CYC       = (ASYNC_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LINK_HALF_CYC        = 6;
	localparam int REFRESH_PERIOD_CYC   = 200;
	localparam int FIFO_DEPTH           = 16;

	// ------------------------------------------------------------
	// Layout and reset values
	// ------------------------------------------------------------
	localparam int         DATA_W        = 16;
	localparam logic [7:0] ROW_END_LOW   = 8'hff;
	localparam logic [22:0] DEV_PIN_IDLE = 23'h3f0000;
	localparam logic [16:0] HOST_PIN_IDLE = 17'h00000;

	typedef enum logic [1:0] {CMD_ASYNC_WRITE, CMD_ASYNC_READ, CMD_BURST_READ, CMD_BURST_WRITE} psb_cmd_type;

	// Wait length of a burst in link clocks; never less than one
	function automatic logic [3:0] psb_lat_cycles(input logic [2:0] code, input logic is_write,
		input logic stretch);
		logic [3:0] n;
		if (is_write) begin
			n = {1'b0, code};
		end else if (stretch) begin
			n = {code, 1'b0};
		end else begin
			n = {1'b0, code} + 4'h1;
		end
		if (n == 4'h0) begin
			n = 4'h1;
		end
		return n;
	endfunction : psb_lat_cycles

endpackage : psb_pkg

// ### rtl/psb_link_if.sv
// Multiplexed bus between the host controller and the memory device
`timescale 1ns/1ps
interface psb_link_if;
	logic        link_clk;
	logic        sel_n;
	logic        oe_n;
	logic        we_n;
	logic        upper_byte_enable_n;
	logic        lower_byte_enable_n;
	logic        address_valid_strobe_n;
	logic [15:0] host_adq_o;
	logic        host_adq_oe;
	logic [15:0] dev_adq_o;
	logic        dev_adq_oe;
	logic        dev_wait_o;
	logic        dev_wait_oe;
	logic [15:0] muxed_addr_data_bus;
	logic        wait_line;

	// Wire resolution; an undriven bus reads as zero
	assign muxed_addr_data_bus = host_adq_oe ? host_adq_o : (dev_adq_oe ? dev_adq_o : 16'h0000);
	assign wait_line           = dev_wait_oe & dev_wait_o;

	modport host (
		output link_clk, sel_n, oe_n, we_n, upper_byte_enable_n, lower_byte_enable_n,
		output address_valid_strobe_n, host_adq_o, host_adq_oe,
		input  muxed_addr_data_bus, wait_line
	);
	modport dev (
		input  link_clk, sel_n, oe_n, we_n, upper_byte_enable_n, lower_byte_enable_n,
		input  address_valid_strobe_n, muxed_addr_data_bus,
		output dev_adq_o, dev_adq_oe, dev_wait_o, dev_wait_oe
	);
endinterface : psb_link_if

// ### rtl/psb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module psb_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) $error("psb_fifo: DEPTH must be a power of two");
	end

	logic [W-1:0]  mem [0:DEPTH-1];
	logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          push, pop;

	// ------------------------------------------------------------
	// Flags and pointers
	// ------------------------------------------------------------
	always_comb begin
		in_ready    = (cnt_reg != FULL);
		out_valid   = (cnt_reg != '0);
		out_data    = mem[rd_ptr_reg];
		push        = in_valid & in_ready;
		pop         = out_valid & out_ready;
		wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
		cnt_next    = cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			cnt_reg    <= cnt_next;
		end
	end

	// Storage carries no reset; only the flags must be defined
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end
endmodule : psb_fifo

// ### rtl/psb_device.sv
// Memory device end: bus sequencing of a multiplexed pseudo-static RAM
//
// Notes on behaviour
// - Host holds link clock still while suspended.
// - Suspended read with output enable keeps driving data.
// - Host deselects soon after row-end wait begins.
// - Low address byte all ones ends a row.
// - Async write commits at first released strobe.
// - Host keeps write enable low under limit.
// - Async write leaves wait undriven when idle.
// - Burst write waits exactly latency-code clocks; code zero gives one clock.
// - Code two gives three-clock read latency.
// - Host deselects within every maximum select interval; a read stalled by a full read buffer keeps the host selected past it.
// - Host deselects before variable-latency read after write.
// - Fixed burst may follow async write without deselect.
// - Host deselect lasts at least minimum deselect time.
// - Without deselect, gap needed after select-ended writes.
// - Write enable at address latch picks direction.
// - Refresh collision stretches variable read latency.
`timescale 1ns/1ps
module psb_device
	import psb_pkg::*;
#(
	parameter int MEM_AW          = 10,
	parameter int REFRESH_CYC     = REFRESH_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Link to the host
	psb_link_if.dev         link,
	// Burst configuration
	input  wire logic [2:0] latency_count_code,
	input  wire logic       cfg_fixed_latency,
	input  wire logic       cfg_wrap,
	// Status
	output logic            stat_selected,
	output logic            stat_burst,
	output logic            stat_refresh_pending
);

	initial begin
		if (MEM_AW < 8 || MEM_AW > 16) $error("psb_device: MEM_AW must lie in 8..16");
		if (REFRESH_CYC < 2 || REFRESH_CYC > 65535) $error("psb_device: REFRESH_CYC out of range");
	end

	localparam logic [15:0] REF_LAST = 16'(REFRESH_CYC - 1);

	typedef enum logic [2:0] {D_IDLE, D_ASYNC, D_LAT, D_DATA, D_ROWEND} psb_dstate_type;

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	logic [22:0] pin_raw, s1_reg, s2_reg, s3_reg, held_reg, held_next;

	always_comb begin
		pin_raw = {link.link_clk, link.sel_n, link.oe_n, link.we_n, link.upper_byte_enable_n,
			link.lower_byte_enable_n, link.address_valid_strobe_n, link.muxed_addr_data_bus};
		// A bit changes only once the second and third stage agree
		held_next = (s2_reg & s3_reg) | (held_reg & (s2_reg | s3_reg));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg   <= DEV_PIN_IDLE;
			s2_reg   <= DEV_PIN_IDLE;
			s3_reg   <= DEV_PIN_IDLE;
			held_reg <= DEV_PIN_IDLE;
		end else begin
			s1_reg   <= pin_raw;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			held_reg <= held_next;
		end
	end

	logic        rise, sel, oe, we, ub, lb, adv, wact;
	logic [15:0] bus;

	always_comb begin
		rise = held_next[22] & ~held_reg[22];
		sel  = ~held_next[21];
		oe   = ~held_next[20];
		we   = ~held_next[19];
		ub   = ~held_next[18];
		lb   = ~held_next[17];
		adv  = ~held_next[16];
		bus  = held_next[15:0];
		wact = sel & we & (ub | lb);
	end

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [15:0]       mem [0:(1 << MEM_AW) - 1];
	logic              mem_we;
	logic [MEM_AW-1:0] mem_addr;
	logic [15:0]       mem_wdata;
	logic [1:0]        mem_be;

	// Byte lanes are written independently
	always_ff @(posedge clk) begin
		if (mem_we && mem_be[0]) begin
			mem[mem_addr][7:0] <= mem_wdata[7:0];
		end
		if (mem_we && mem_be[1]) begin
			mem[mem_addr][15:8] <= mem_wdata[15:8];
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	psb_dstate_type state_reg, state_next;
	logic [15:0] addr_reg, addr_next;
	logic [3:0]  lat_reg, lat_next;
	logic        is_wr_reg, is_wr_next;
	logic        wact_reg;
	logic [15:0] wdata_reg, wdata_next;
	logic [1:0]  wbe_reg, wbe_next;
	logic        wait_reg, wait_next;
	logic [15:0] ref_cnt_reg, ref_cnt_next;
	logic        ref_pend_reg, ref_pend_next;
	logic        in_burst;

	always_comb begin
		state_next    = state_reg;
		addr_next     = addr_reg;
		lat_next      = lat_reg;
		is_wr_next    = is_wr_reg;
		wdata_next    = wdata_reg;
		wbe_next      = wbe_reg;
		wait_next     = wait_reg;
		ref_pend_next = ref_pend_reg;
		ref_cnt_next  = ref_cnt_reg;
		mem_we        = 1'b0;
		mem_addr      = addr_reg[MEM_AW-1:0];
		mem_wdata     = wdata_reg;
		mem_be        = wbe_reg;
		case (state_reg)
			D_IDLE: begin
				if (sel) begin
					state_next = D_ASYNC;
				end
			end
			D_ASYNC: begin
				if (adv) begin
					addr_next = bus;
				end
				if (wact) begin
					wdata_next = bus;
					wbe_next   = {ub, lb};
				end
				// Whichever strobe lets go first ends the write
				if (wact_reg && !wact) begin
					mem_we = 1'b1;
				end
				// A clocked address latch starts a burst, even straight after an async write
				if (sel && rise && adv) begin
					state_next = D_LAT;
					addr_next  = bus;
					is_wr_next = we;
					lat_next   = psb_lat_cycles(latency_count_code, we,
						ref_pend_reg & ~cfg_fixed_latency);
					wait_next  = 1'b1;
					if (!we && !cfg_fixed_latency) begin
						ref_pend_next = 1'b0;
					end
				end
			end
			D_LAT: begin
				if (rise) begin
					if (lat_reg == 4'h1) begin
						state_next = D_DATA;
						wait_next  = 1'b0;
					end else begin
						lat_next = lat_reg - 4'h1;
					end
				end
			end
			D_DATA: begin
				// A rising edge while wait is clear moves one word
				if (rise) begin
					if (is_wr_reg) begin
						mem_we    = 1'b1;
						mem_wdata = bus;
						mem_be    = {ub, lb};
					end
					if (addr_reg[7:0] == ROW_END_LOW && !cfg_wrap) begin
						state_next = D_ROWEND;
						wait_next  = 1'b1;
					end else if (cfg_wrap) begin
						addr_next = {addr_reg[15:8], addr_reg[7:0] + 8'h01};
					end else begin
						addr_next = addr_reg + 16'h0001;
					end
				end
			end
			D_ROWEND: begin
				// Held waiting until the host deselects
				wait_next = 1'b1;
			end
			default: begin
				state_next = D_IDLE;
			end
		endcase
		// Deselect ends any access and lets the hidden refresh run
		if (!sel) begin
			state_next    = D_IDLE;
			wait_next     = 1'b0;
			ref_pend_next = 1'b0;
			ref_cnt_next  = 16'h0000;
		end else if (ref_cnt_reg == REF_LAST) begin
			ref_pend_next = 1'b1;
		end else begin
			ref_cnt_next = ref_cnt_reg + 16'h0001;
		end
		in_burst = (state_next == D_LAT) || (state_next == D_DATA) || (state_next == D_ROWEND);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg    <= D_IDLE;
			addr_reg     <= 16'h0000;
			lat_reg      <= 4'h1;
			is_wr_reg    <= 1'b0;
			wact_reg     <= 1'b0;
			wdata_reg    <= 16'h0000;
			wbe_reg      <= 2'h0;
			wait_reg     <= 1'b0;
			ref_cnt_reg  <= 16'h0000;
			ref_pend_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			addr_reg     <= addr_next;
			lat_reg      <= lat_next;
			is_wr_reg    <= is_wr_next;
			wact_reg     <= wact & (state_reg == D_ASYNC);
			wdata_reg    <= wdata_next;
			wbe_reg      <= wbe_next;
			wait_reg     <= wait_next;
			ref_cnt_reg  <= ref_cnt_next;
			ref_pend_reg <= ref_pend_next;
		end
	end

	// ------------------------------------------------------------
	// Pin drivers and status
	// ------------------------------------------------------------
	logic [15:0] adq_o_next;
	logic        adq_oe_next, wait_oe_next;

	always_comb begin
		// Data follows the current address; one cycle late, well inside half a link clock
		adq_o_next  = mem[addr_reg[MEM_AW-1:0]];
		adq_oe_next = 1'b0;
		if ((state_reg == D_DATA || state_reg == D_ROWEND) && !is_wr_reg && oe) begin
			adq_oe_next = 1'b1;
		end else if (state_reg == D_ASYNC && oe && !we && !adv) begin
			adq_oe_next = 1'b1;
		end
		// Wait floats during async writes and, outside bursts, whenever output enable is off
		wait_oe_next = sel & (in_burst | ((state_next == D_ASYNC) & oe & ~we));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link.dev_adq_o       <= 16'h0000;
			link.dev_adq_oe      <= 1'b0;
			link.dev_wait_o      <= 1'b0;
			link.dev_wait_oe     <= 1'b0;
			stat_selected        <= 1'b0;
			stat_burst           <= 1'b0;
			stat_refresh_pending <= 1'b0;
		end else begin
			link.dev_adq_o       <= adq_o_next;
			link.dev_adq_oe      <= adq_oe_next;
			link.dev_wait_o      <= wait_next & in_burst;
			link.dev_wait_oe     <= wait_oe_next;
			stat_selected        <= sel;
			stat_burst           <= in_burst;
			stat_refresh_pending <= ref_pend_next;
		end
	end

endmodule : psb_device

// ### rtl/psb_host.sv
// Host controller end: drives the multiplexed bus and buffers read data
`timescale 1ns/1ps
module psb_host
	import psb_pkg::*;
#(
	parameter int HALF_CYC   = LINK_HALF_CYC,
	parameter int DEPTH      = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Link to the device
	psb_link_if.host         link,
	// Command port
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire psb_cmd_type cmd_kind,
	input  wire logic [15:0] cmd_addr,
	input  wire logic [15:0] cmd_wdata,
	input  wire logic [7:0]  cmd_len,
	// Read data
	output logic             rd_valid,
	input  wire logic        rd_ready,
	output logic [15:0]      rd_data,
	// Status
	output logic             op_truncated
);
	initial begin
		if (HALF_CYC < 6 || HALF_CYC > 255) $error("psb_host: HALF_CYC must lie in 6..255");
	end

	localparam logic [7:0]  HALF_LAST = 8'(HALF_CYC - 1);
	localparam logic [7:0]  STEP_N    = 8'(ASYNC_STEP_CYC);
	localparam logic [7:0]  DESEL_N   = 8'(MIN_DESELECT_CYC);
	localparam logic [15:0] SEL_LIMIT = 16'(MAX_SELECT_PULSE_CYC - 4 * HALF_CYC);

	typedef enum logic [2:0] {H_IDLE, H_ASYNC, H_BADDR, H_BDATA, H_DESEL} psb_hstate_type;

	// ------------------------------------------------------------
	// Synchroniser for wait and bus
	// ------------------------------------------------------------
	logic [16:0] s1_reg, s2_reg, s3_reg, held_reg, held_next;
	logic        wait_s;
	logic [15:0] bus_s;

	always_comb begin
		held_next = (s2_reg & s3_reg) | (held_reg & (s2_reg | s3_reg));
		wait_s    = held_next[16];
		bus_s     = held_next[15:0];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg   <= HOST_PIN_IDLE;
			s2_reg   <= HOST_PIN_IDLE;
			s3_reg   <= HOST_PIN_IDLE;
			held_reg <= HOST_PIN_IDLE;
		end else begin
			s1_reg   <= {link.wait_line, link.muxed_addr_data_bus};
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			held_reg <= held_next;
		end
	end

	// ------------------------------------------------------------
	// Read buffer
	// ------------------------------------------------------------
	logic fifo_in_valid, fifo_in_ready;

	psb_fifo #(.W(16), .DEPTH(DEPTH)) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (bus_s),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	// ------------------------------------------------------------
	// Sequencer and link clock divider
	// ------------------------------------------------------------
	psb_hstate_type state_reg, state_next;
	psb_cmd_type kind_reg, kind_next;
	logic [7:0]  div_reg, div_next, tmr_reg, tmr_next, left_reg, left_next;
	logic [1:0]  step_reg, step_next;
	logic [15:0] wdata_reg, wdata_next, selc_reg, selc_next, adq_next;
	logic        lclk_next, sel_n_next, oe_n_next, we_n_next, be_n_next, adv_n_next, adq_oe_next;
	logic        got_reg, got_next, end_reg, end_next, trunc_next;
	logic        tick, rise_tick, fall_tick, reading, wr_kind;

	always_comb begin
		state_next = state_reg;
		kind_next  = kind_reg;
		tmr_next   = tmr_reg;
		left_next  = left_reg;
		step_next  = step_reg;
		wdata_next = wdata_reg;
		got_next   = got_reg;
		end_next   = end_reg;
		trunc_next = op_truncated;
		sel_n_next = link.sel_n;
		oe_n_next  = link.oe_n;
		we_n_next  = link.we_n;
		be_n_next  = link.upper_byte_enable_n;
		adv_n_next = link.address_valid_strobe_n;
		adq_next   = link.host_adq_o;
		adq_oe_next = link.host_adq_oe;
		fifo_in_valid = 1'b0;
		wr_kind    = (kind_reg == CMD_BURST_WRITE) || (kind_reg == CMD_ASYNC_WRITE);
		reading    = (state_reg == H_BDATA) && (kind_reg == CMD_BURST_READ);
		tick       = (div_reg == HALF_LAST);
		// The clock stops low while the buffer is full, suspending the burst
		rise_tick  = tick && !link.link_clk && !(reading && !fifo_in_ready);
		fall_tick  = tick && link.link_clk;
		div_next   = (state_reg == H_BADDR || state_reg == H_BDATA) && !tick ? div_reg + 8'h01 : 8'h00;
		if (tick && !rise_tick && !fall_tick) begin
			div_next = div_reg;
		end
		lclk_next  = rise_tick ? 1'b1 : (fall_tick ? 1'b0 : link.link_clk);
		selc_next  = link.sel_n ? 16'h0000 : selc_reg + 16'h0001;
		tmr_next   = (tmr_reg != 8'h00) ? tmr_reg - 8'h01 : 8'h00;
		case (state_reg)
			H_IDLE: begin
				// A command offered while ready is low has no effect
				if (cmd_valid && cmd_ready) begin
					kind_next   = cmd_kind;
					wdata_next  = cmd_wdata;
					left_next   = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
					got_next    = 1'b0;
					end_next    = 1'b0;
					trunc_next  = 1'b0;
					sel_n_next  = 1'b0;
					adv_n_next  = 1'b0;
					adq_next    = cmd_addr;
					adq_oe_next = 1'b1;
					be_n_next   = 1'b0;
					// Direction is set before the address is latched
					we_n_next   = (cmd_kind != CMD_BURST_WRITE);
					step_next   = 2'h0;
					tmr_next    = STEP_N;
					state_next  = (cmd_kind == CMD_ASYNC_WRITE || cmd_kind == CMD_ASYNC_READ) ? H_ASYNC : H_BADDR;
				end
			end
			H_ASYNC: begin
				if (tmr_reg == 8'h01) begin
					tmr_next  = STEP_N;
					step_next = step_reg + 2'h1;
					if (step_reg == 2'h0) begin
						adv_n_next  = 1'b1;
						adq_next    = wdata_reg;
						adq_oe_next = wr_kind;
						we_n_next   = !wr_kind;
						oe_n_next   = wr_kind;
					end else if (step_reg == 2'h1) begin
						we_n_next = 1'b1;
					end else begin
						// Read data is taken two whole steps after output enable, since the round trip
						// through both synchronisers outlasts a single step
						fifo_in_valid = !wr_kind;
						if (!wr_kind && !fifo_in_ready) begin
							tmr_next  = 8'h01;
							step_next = step_reg;
						end else begin
							end_next = 1'b1;
						end
					end
				end
			end
			H_BADDR: begin
				if (rise_tick) begin
					state_next = H_BDATA;
				end
			end
			H_BDATA: begin
				if (fall_tick) begin
					adv_n_next  = 1'b1;
					adq_next    = wdata_reg;
					adq_oe_next = wr_kind;
					oe_n_next   = wr_kind;
				end
				if (rise_tick) begin
					// Words move only on edges where wait is clear
					if (!wait_s) begin
						fifo_in_valid = !wr_kind;
						got_next      = 1'b1;
						wdata_next    = wdata_reg + 16'h0001;
						left_next     = left_reg - 8'h01;
						end_next      = (left_reg == 8'h01);
					end else if (got_reg) begin
						end_next   = 1'b1;
						trunc_next = 1'b1;
					end
				end
				if (selc_reg >= SEL_LIMIT) begin
					end_next   = 1'b1;
					trunc_next = 1'b1;
				end
			end
			default: begin
				if (tmr_reg == 8'h00) begin
					state_next = H_IDLE;
				end
			end
		endcase
		// Every access ends in a deselect, which also serves refresh and mode changes
		if (end_next && state_reg != H_DESEL && (state_reg == H_ASYNC || fall_tick)) begin
			state_next  = H_DESEL;
			sel_n_next  = 1'b1;
			oe_n_next   = 1'b1;
			we_n_next   = 1'b1;
			be_n_next   = 1'b1;
			adv_n_next  = 1'b1;
			adq_oe_next = 1'b0;
			tmr_next    = DESEL_N;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= H_IDLE;
			kind_reg  <= CMD_ASYNC_WRITE;
			div_reg   <= 8'h00;
			tmr_reg   <= 8'h00;
			left_reg  <= 8'h00;
			step_reg  <= 2'h0;
			wdata_reg <= 16'h0000;
			selc_reg  <= 16'h0000;
			got_reg   <= 1'b0;
			end_reg   <= 1'b0;
			cmd_ready <= 1'b0;
			op_truncated <= 1'b0;
			link.link_clk <= 1'b0;
			link.sel_n    <= 1'b1;
			link.oe_n     <= 1'b1;
			link.we_n     <= 1'b1;
			link.upper_byte_enable_n    <= 1'b1;
			link.lower_byte_enable_n    <= 1'b1;
			link.address_valid_strobe_n <= 1'b1;
			link.host_adq_o  <= 16'h0000;
			link.host_adq_oe <= 1'b0;
		end else begin
			state_reg <= state_next;
			kind_reg  <= kind_next;
			div_reg   <= div_next;
			tmr_reg   <= tmr_next;
			left_reg  <= left_next;
			step_reg  <= step_next;
			wdata_reg <= wdata_next;
			selc_reg  <= selc_next;
			got_reg   <= got_next;
			end_reg   <= end_next;
			cmd_ready <= (state_next == H_IDLE) && !(state_reg == H_IDLE && cmd_valid && cmd_ready);
			op_truncated <= trunc_next;
			link.link_clk <= lclk_next;
			link.sel_n    <= sel_n_next;
			link.oe_n     <= oe_n_next;
			link.we_n     <= we_n_next;
			link.upper_byte_enable_n    <= be_n_next;
			link.lower_byte_enable_n    <= be_n_next;
			link.address_valid_strobe_n <= adv_n_next;
			link.host_adq_o  <= adq_next;
			link.host_adq_oe <= adq_oe_next;
		end
	end
endmodule : psb_host

// ### tb/psb_link_sva.sv
// Link checker watching the signals between host and device
`timescale 1ns/1ps
module psb_link_sva
	import psb_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link signals
	input wire logic link_clk,
	input wire logic sel_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic address_valid_strobe_n,
	input wire logic host_adq_oe,
	input wire logic dev_adq_oe,
	input wire logic dev_wait_oe,
	input wire logic wait_line
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	int sel_cnt;
	// Select length; a host that never deselects starves refresh
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			sel_cnt <= 0;
		else
			sel_cnt <= sel_n ? 0 : sel_cnt + 1;
	end
	a_bus_no_fight: assert property (!(host_adq_oe && dev_adq_oe)) else $error("bus fight");
	a_suspend_drive: assert property (!oe_n && !sel_n && $past(dev_adq_oe) |-> dev_adq_oe) else $error("drop");
	a_desel_gap: assert property ($rose(sel_n) |-> sel_n[*5]) else $error("short gap");
	a_select_max: assert property (sel_cnt < MAX_SELECT_PULSE_CYC) else $error("select too long");
	a_write_low_max: assert property (!we_n |-> sel_cnt < MAX_SELECT_PULSE_CYC) else $error("we too long");
	a_clock_idle: assert property (sel_n |-> !link_clk) else $error("clock runs idle");
	a_wait_freed: assert property ($rose(sel_n) |-> ##[1:8] !dev_wait_oe) else $error("wait held");
	a_latch_drive: assert property ($rose(link_clk) && !address_valid_strobe_n |-> host_adq_oe && !sel_n)
		else $error("no address");
	c_write: cover property ($fell(sel_n) ##1 !we_n);
	c_wait: cover property ($rose(link_clk) && wait_line);
	c_hold: cover property ((!oe_n && dev_adq_oe && !link_clk)[*8]);
endmodule : psb_link_sva

// ### tb/psram_burst_async_bus_sequencing_tb_top.sv
// Bench joining host and device ends over the link
`timescale 1ns/1ps
module psram_burst_async_bus_sequencing_tb_top
	import psb_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, rd_ready = 1'b0, cfg_fixed_latency = 1'b1, cfg_wrap = 1'b1;
	logic        cmd_ready, rd_valid, op_truncated, lk_q, sel_q;
	psb_cmd_type cmd_kind = CMD_ASYNC_WRITE;
	logic [15:0] cmd_addr = 16'h0000, cmd_wdata = 16'h0000, rd_data, a, d;
	logic [7:0]  cmd_len = 8'h01;
	logic [2:0]  latency_count_code = 3'h2;
	logic [31:0] seed = 32'h00000045;
	int          miscompares = 0, n_compared = 0, wc;
	psb_link_if lk ();
	always #10 clk = ~clk;
	psb_host psb_host_i (.clk, .rst, .link(lk), .cmd_valid, .cmd_ready, .cmd_kind, .cmd_addr, .cmd_wdata, .cmd_len,
		.rd_valid, .rd_ready, .rd_data, .op_truncated);
	psb_device psb_device_i (.clk, .rst, .link(lk), .latency_count_code, .cfg_fixed_latency, .cfg_wrap,
		.stat_selected(), .stat_burst(), .stat_refresh_pending());
	psb_link_sva psb_link_sva_i (.clk, .rst, .link_clk(lk.link_clk), .sel_n(lk.sel_n), .oe_n(lk.oe_n), .we_n(lk.we_n),
		.address_valid_strobe_n(lk.address_valid_strobe_n), .host_adq_oe(lk.host_adq_oe),
		.dev_adq_oe(lk.dev_adq_oe), .dev_wait_oe(lk.dev_wait_oe), .wait_line(lk.wait_line));
	// Wait clocks as the host sees them, restarted at each select
	always @(posedge clk) begin
		lk_q <= lk.link_clk;
		sel_q <= lk.sel_n;
		if (sel_q && !lk.sel_n)
			wc <= 0;
		else if (lk.link_clk && !lk_q && lk.wait_line)
			wc <= wc + 1;
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Code zero clamps to one clock
	function logic [15:0] lat(logic w, logic [2:0] c);
		return (c == 3'h0) ? 16'h0001 : (w ? 16'(c) : 16'(c) + 16'h0001);
	endfunction : lat
	task tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	task chk(logic [15:0] s, logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task ready();
		int i;
		for (i = 0; i < 4000 && cmd_ready !== 1'b1; i++)
			@(posedge clk);
		if (i == 4000) begin
			miscompares++;
			tally_and_finish();
		end
	endtask : ready
	// Ends one edge after the take so cmd_ready has dropped
	task cmd(psb_cmd_type k, logic [15:0] ad, logic [15:0] v, logic [7:0] n);
		ready();
		cmd_kind <= k;
		cmd_addr <= ad;
		cmd_wdata <= v;
		cmd_len <= n;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(posedge clk);
	endtask : cmd
	task pop(logic [15:0] e);
		int i;
		rd_ready <= 1'b1;
		for (i = 0; i < 4000; i++) begin
			@(posedge clk);
			if (rd_ready === 1'b1 && rd_valid === 1'b1)
				break;
		end
		if (i == 4000) begin
			miscompares++;
			tally_and_finish();
		end
		chk(rd_data, e);
		rd_ready <= 1'b0;
		@(posedge clk);
	endtask : pop
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		for (int c = 0; c < 4; c++) begin
			latency_count_code <= 3'(c);
			cfg_fixed_latency <= c[0];
			a = 16'(rnd()) & 16'h03f0;
			d = 16'(rnd());
			cmd(CMD_BURST_WRITE, a, d, 8'h03);
			ready();
			chk(16'(wc), lat(1'b1, 3'(c)));
			cmd(CMD_BURST_READ, a, 16'h0000, 8'h03);
			ready();
			chk(16'(wc), lat(1'b0, 3'(c)));
			chk(16'(op_truncated), 16'h0000);
			for (int i = 0; i < 3; i++)
				pop(d + 16'(i));
		end
		$display("latency test done");
		for (int i = 0; i < 3; i++) begin
			a = 16'(rnd()) & 16'h03ff;
			d = 16'(rnd());
			cmd(CMD_ASYNC_WRITE, a, d, 8'h01);
			cmd(CMD_ASYNC_READ, a, 16'h0000, 8'h01);
			pop(d);
		end
		$display("async test done");
		// Fill the read buffer so the last burst must suspend
		latency_count_code <= 3'h2;
		cmd(CMD_BURST_WRITE, 16'h0100, d, 8'h07);
		cmd(CMD_BURST_READ, 16'h0100, 16'h0000, 8'h07);
		cmd(CMD_BURST_READ, 16'h0100, 16'h0000, 8'h07);
		cmd(CMD_BURST_READ, 16'h0100, 16'h0000, 8'h04);
		repeat (80) @(posedge clk);
		for (int i = 0; i < 18; i++)
			pop(d + 16'(i % 7));
		$display("suspend test done");
		cfg_wrap <= 1'b0;
		cmd(CMD_BURST_WRITE, 16'h00fd, d, 8'h03);
		cmd(CMD_BURST_READ, 16'h00fd, 16'h0000, 8'h04);
		ready();
		chk(16'(op_truncated), 16'h0001);
		for (int i = 0; i < 3; i++)
			pop(d + 16'(i));
		$display("row end test done");
		tally_and_finish();
	end
endmodule : psram_burst_async_bus_sequencing_tb_top
